/* File: pfp_pkg.sv */
// constants shared by the parallel flash program port
package pfp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W     = 16;
  localparam int MODE_W     = 4;
  localparam int ADDR_W     = 32;
  localparam int PAGE_LOG2  = 4;
  localparam int PAGE_WORDS = 16;
  localparam int LOCK_LSB   = 7;
  localparam int LOCK_IDX_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 5;
  localparam int PIN_W      = 22;

  // ----------------------------------------------------------------
  // mode selector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_CMD     = 4'h0;
  localparam logic [3:0] MODE_ADDR_LO = 4'h1;
  localparam logic [3:0] MODE_ADDR_HI = 4'h2;
  localparam logic [3:0] MODE_DATA    = 4'h5;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_NONE            = 16'h0000;
  localparam logic [15:0] CMD_READ            = 16'h0011;
  localparam logic [15:0] CMD_PAGE_WRITE      = 16'h0012;
  localparam logic [15:0] CMD_PAGE_WRITE_LOCK = 16'h0022;
  localparam logic [15:0] CMD_ERASE_WRITE     = 16'h0032;
  localparam logic [15:0] CMD_ERASE_WRITE_LCK = 16'h0042;
  localparam logic [15:0] CMD_FULL_ERASE      = 16'h0013;
  localparam logic [15:0] CMD_SET_LOCK        = 16'h0014;
  localparam logic [15:0] CMD_CLEAR_LOCK      = 16'h0024;
  localparam logic [15:0] CMD_GET_LOCK        = 16'h0015;
  localparam logic [15:0] CMD_SET_USER_BIT    = 16'h0034;
  localparam logic [15:0] CMD_CLEAR_USER_BIT  = 16'h0044;
  localparam logic [15:0] CMD_GET_USER_BIT    = 16'h0025;

  // ----------------------------------------------------------------
  // flash back-end operation codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_ERASE_PAGE = 2'h0;
  localparam logic [1:0] OP_PROGRAM    = 2'h1;
  localparam logic [1:0] OP_ERASE_ALL  = 2'h2;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [21:0] PIN_RST   = 22'h3FFFFF;
  localparam logic        READY_RST = 1'b1;
  localparam logic        VALID_RST = 1'b1;
  localparam logic [15:0] BITS_RST  = 16'h0000;

endpackage

/* File: pfp_fifo.sv */
// page load buffer fifo with valid/ready on both sides
`timescale 1ns/1ps
module pfp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rstN,
  input  wire logic                     ce,
  input  wire logic                     inValid,
  output logic                          inReady,
  input  wire logic [WIDTH-1:0]         inData,
  output logic                          outValid,
  input  wire logic                     outReady,
  output logic [WIDTH-1:0]              outData,
  output logic [$clog2(DEPTH+1)-1:0]    count
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0]           mem_ff [DEPTH];
  logic [PW-1:0]              wrPtr_ff;
  logic [PW-1:0]              rdPtr_ff;
  logic [$clog2(DEPTH+1)-1:0] cnt_ff;
  logic                       push;
  logic                       pop;

  assign inReady  = (cnt_ff != ($clog2(DEPTH+1))'(DEPTH));
  assign outValid = (cnt_ff != '0);
  assign outData  = mem_ff[rdPtr_ff];
  assign count    = cnt_ff;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (ce && push)
    begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  // ----------------------------------------------------------------
  // pointers and fill level
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff   <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wrPtr_ff <= (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + PW'(1);
      end
      if (pop)
      begin
        rdPtr_ff <= (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + PW'(1);
      end
      if (push && !pop)
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  full_no_ready_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    (cnt_ff == ($clog2(DEPTH+1))'(DEPTH)) |-> !inReady)
    else $error("fifo full but ready");
  count_step_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    (ce && push && !pop) |=> (cnt_ff == $past(cnt_ff) + 1'b1))
    else $error("fifo count did not rise on push");

endmodule

/* File: pfp_flash_port.sv */
// parallel flash program port: pin handshake and command interpreter
`timescale 1ns/1ps
// How it works
// - on output enable low the device drives the word, then lowers data valid.
// - on output enable high device floats the bus, then raises data valid.
// - after data valid high programmer raises strobe; device then raises ready.
// - a new command completes the previous one, committing pending page data.
// - read is command, low and high address, then reads returning words.
// - reads start anywhere; address may be reloaded at any point.
// - written words collect in a page buffer, committed before other-page access.
// - the page buffer is committed whenever a command-mode word arrives.
// - page write is command, addresses, then data writes storing words, address advancing.
// - write-and-lock sets the region lock bit after the flash write.
// - erase variants erase the page before programming; one also locks.
// - full erase needs data zero; aborts if any region is locked.
// - successful full erase clears all lock and user bits.
// - set and clear lock take a mask; bit n acts on lock n.
// - get lock returns the lock mask in one read handshake.
// - set and clear user bits take a pattern; ones select bits.
// - get user bits returns the user bit mask in one read.
// - mode selects command, low address, high address, data, or nothing.
// - read, page write and full erase have fixed 16-bit codes.
// - set, clear and get lock have fixed 16-bit codes.
// - handshakes start only with ready high; done when strobe and ready high.
module pfp_flash_port (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        commandStrobeN,
  input  wire logic        outputEnableN,
  input  wire logic [3:0]  modeSel,
  input  wire logic [15:0] dataIn,
  output logic [15:0]      dataOut,
  output logic             dataOe,
  output logic             ready,
  output logic             dataValidN,
  output logic             flashOp,
  output logic [1:0]       flashOpSel,
  output logic [31:0]      flashAddr,
  output logic [4:0]       flashLen,
  output logic [15:0]      flashWdata,
  output logic             flashWvalid,
  input  wire logic        flashWready,
  input  wire logic        flashDone,
  output logic             flashRdReq,
  input  wire logic        flashRdValid,
  input  wire logic [15:0] flashRdata,
  output logic [15:0]      lockBits,
  output logic [15:0]      userBits
);

  typedef enum logic [10:0] {
    ST_IDLE    = 11'h001,
    ST_DECODE  = 11'h002,
    ST_ERASE   = 11'h004,
    ST_PROG    = 11'h008,
    ST_ERALL   = 11'h010,
    ST_RDWAIT  = 11'h020,
    ST_RDFETCH = 11'h040,
    ST_RDVALID = 11'h080,
    ST_RDHOLD  = 11'h100,
    ST_RDEND   = 11'h200,
    ST_WAITHI  = 11'h400
  } pfp_state_e;

  pfp_state_e   state_ff;
  logic         rstMeta_ff;
  logic         rstN;
  logic [21:0]  pinS1_ff;
  logic [21:0]  pinS2_ff;
  logic [21:0]  pinS3_ff;
  logic [21:0]  pinF_ff;
  logic         cmdNF;
  logic         oeNF;
  logic [3:0]   mode_ff;
  logic [15:0]  word_ff;
  logic [15:0]  cmd_ff;
  logic [31:0]  addr_ff;
  logic [31:0]  bufStart_ff;
  logic [31:0]  bufEnd;
  logic [15:0]  dataOut_ff;
  logic         dataOe_ff;
  logic         ready_ff;
  logic         valid_ff;
  logic         flashOp_ff;
  logic [1:0]   opSel_ff;
  logic [31:0]  flashAddr_ff;
  logic [4:0]   flashLen_ff;
  logic [15:0]  wdata_ff;
  logic         wvalid_ff;
  logic         rdReq_ff;
  logic [15:0]  lock_ff;
  logic [15:0]  user_ff;
  logic         isWriteCmd;
  logic         isLockVar;
  logic         isEraseVar;
  logic         dirty;
  logic         pageMiss;
  logic         needCommit;
  logic         fifoInValid;
  logic         fifoInReady;
  logic         fifoOutValid;
  logic         fifoOutReady;
  logic [15:0]  fifoOutData;
  logic [4:0]   fifoCount;
  logic [3:0]   lockIdx;

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_ff <= 1'b0;
      rstN       <= 1'b0;
    end
    else
    begin
      rstMeta_ff <= 1'b1;
      rstN       <= rstMeta_ff;
    end
  end

  // a bit changes only once the second and third stages agree
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      pinS1_ff <= pfp_pkg::PIN_RST;
      pinS2_ff <= pfp_pkg::PIN_RST;
      pinS3_ff <= pfp_pkg::PIN_RST;
      pinF_ff  <= pfp_pkg::PIN_RST;
    end
    else if (ce)
    begin
      pinS1_ff <= {commandStrobeN, outputEnableN, modeSel, dataIn};
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      pinF_ff  <= ((pinS2_ff ~^ pinS3_ff) & pinS3_ff) | ((pinS2_ff ^ pinS3_ff) & pinF_ff);
    end
  end

  assign cmdNF = pinF_ff[21];
  assign oeNF  = pinF_ff[20];

  // ----------------------------------------------------------------
  // command decode and page buffer bookkeeping
  // ----------------------------------------------------------------
  assign isLockVar  = (cmd_ff == pfp_pkg::CMD_PAGE_WRITE_LOCK) || (cmd_ff == pfp_pkg::CMD_ERASE_WRITE_LCK);
  assign isEraseVar = (cmd_ff == pfp_pkg::CMD_ERASE_WRITE) || (cmd_ff == pfp_pkg::CMD_ERASE_WRITE_LCK);
  assign isWriteCmd = (cmd_ff == pfp_pkg::CMD_PAGE_WRITE) || isLockVar || isEraseVar;
  assign dirty      = (fifoCount != '0);
  assign bufEnd     = bufStart_ff + 32'(fifoCount);
  // a gap inside the page also forces a commit, since the buffer holds a contiguous run
  assign pageMiss   = (addr_ff != bufEnd)
                   || (addr_ff[31:pfp_pkg::PAGE_LOG2] != bufStart_ff[31:pfp_pkg::PAGE_LOG2]);
  assign needCommit = dirty && ((mode_ff == pfp_pkg::MODE_CMD)
                   || ((mode_ff == pfp_pkg::MODE_DATA) && pageMiss));
  assign fifoInValid  = (state_ff == ST_DECODE) && !needCommit && (mode_ff == pfp_pkg::MODE_DATA) && isWriteCmd;
  assign fifoOutReady = (state_ff == ST_PROG) && flashWready && !wvalid_ff;
  assign lockIdx      = bufStart_ff[pfp_pkg::LOCK_LSB +: pfp_pkg::LOCK_IDX_W];

  pfp_fifo #(
    .WIDTH (pfp_pkg::DATA_W),
    .DEPTH (pfp_pkg::FIFO_DEPTH)
  ) u_loadBuf (
    .clk_sys  (clk_sys),
    .rstN     (rstN),
    .ce       (ce),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (word_ff),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData),
    .count    (fifoCount)
  );

  // ----------------------------------------------------------------
  // handshake and command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      state_ff     <= ST_IDLE;
      mode_ff      <= pfp_pkg::MODE_CMD;
      word_ff      <= 16'h0000;
      cmd_ff       <= pfp_pkg::CMD_NONE;
      addr_ff      <= 32'h00000000;
      bufStart_ff  <= 32'h00000000;
      dataOut_ff   <= 16'h0000;
      dataOe_ff    <= 1'b0;
      ready_ff     <= pfp_pkg::READY_RST;
      valid_ff     <= pfp_pkg::VALID_RST;
      flashOp_ff   <= 1'b0;
      opSel_ff     <= pfp_pkg::OP_ERASE_PAGE;
      flashAddr_ff <= 32'h00000000;
      flashLen_ff  <= 5'h00;
      wdata_ff     <= 16'h0000;
      wvalid_ff    <= 1'b0;
      rdReq_ff     <= 1'b0;
      lock_ff      <= pfp_pkg::BITS_RST;
      user_ff      <= pfp_pkg::BITS_RST;
    end
    else if (ce)
    begin
      flashOp_ff <= 1'b0;
      rdReq_ff   <= 1'b0;
      wvalid_ff  <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
        begin
          if (!cmdNF)
          begin
            mode_ff  <= pinF_ff[19:16];
            word_ff  <= pinF_ff[15:0];
            ready_ff <= 1'b0;
            state_ff <= ST_DECODE;
          end
        end
        ST_DECODE:
        begin
          if (needCommit)
          begin
            flashOp_ff   <= 1'b1;
            flashAddr_ff <= bufStart_ff;
            flashLen_ff  <= fifoCount;
            opSel_ff     <= isEraseVar ? pfp_pkg::OP_ERASE_PAGE : pfp_pkg::OP_PROGRAM;
            state_ff     <= isEraseVar ? ST_ERASE : ST_PROG;
          end
          else
          begin
            state_ff <= ST_WAITHI;
            case (mode_ff)
              pfp_pkg::MODE_CMD:     cmd_ff <= word_ff;
              pfp_pkg::MODE_ADDR_LO: addr_ff[15:0] <= word_ff;
              pfp_pkg::MODE_ADDR_HI: addr_ff[31:16] <= word_ff;
              pfp_pkg::MODE_DATA:
              begin
                case (cmd_ff)
                  pfp_pkg::CMD_READ, pfp_pkg::CMD_GET_LOCK, pfp_pkg::CMD_GET_USER_BIT:
                    state_ff <= ST_RDWAIT;
                  pfp_pkg::CMD_PAGE_WRITE, pfp_pkg::CMD_PAGE_WRITE_LOCK,
                  pfp_pkg::CMD_ERASE_WRITE, pfp_pkg::CMD_ERASE_WRITE_LCK:
                  begin
                    if (fifoInReady)
                    begin
                      if (!dirty)
                      begin
                        bufStart_ff <= addr_ff;
                      end
                      addr_ff <= addr_ff + 32'h00000001;
                    end
                    else
                    begin
                      state_ff <= ST_DECODE;
                    end
                  end
                  pfp_pkg::CMD_FULL_ERASE:
                  begin
                    if ((word_ff == 16'h0000) && (lock_ff == 16'h0000))
                    begin
                      flashOp_ff <= 1'b1;
                      opSel_ff   <= pfp_pkg::OP_ERASE_ALL;
                      state_ff   <= ST_ERALL;
                    end
                  end
                  pfp_pkg::CMD_SET_LOCK:       lock_ff <= lock_ff | word_ff;
                  pfp_pkg::CMD_CLEAR_LOCK:     lock_ff <= lock_ff & ~word_ff;
                  pfp_pkg::CMD_SET_USER_BIT:   user_ff <= user_ff | word_ff;
                  pfp_pkg::CMD_CLEAR_USER_BIT: user_ff <= user_ff & ~word_ff;
                  default:
                  begin
                  end
                endcase
              end
              default:
              begin
              end
            endcase
          end
        end
        ST_ERASE:
        begin
          if (flashDone)
          begin
            flashOp_ff <= 1'b1;
            opSel_ff   <= pfp_pkg::OP_PROGRAM;
            state_ff   <= ST_PROG;
          end
        end
        ST_PROG:
        begin
          if (fifoOutValid && fifoOutReady)
          begin
            wdata_ff  <= fifoOutData;
            wvalid_ff <= 1'b1;
          end
          if (flashDone)
          begin
            if (isLockVar)
            begin
              lock_ff[lockIdx] <= 1'b1;
            end
            state_ff <= ST_DECODE;
          end
        end
        ST_ERALL:
        begin
          if (flashDone)
          begin
            lock_ff  <= 16'h0000;
            user_ff  <= 16'h0000;
            state_ff <= ST_WAITHI;
          end
        end
        ST_RDWAIT:
        begin
          if (!oeNF)
          begin
            if (cmd_ff == pfp_pkg::CMD_READ)
            begin
              rdReq_ff     <= 1'b1;
              flashAddr_ff <= addr_ff;
              state_ff     <= ST_RDFETCH;
            end
            else
            begin
              dataOut_ff <= (cmd_ff == pfp_pkg::CMD_GET_LOCK) ? lock_ff : user_ff;
              dataOe_ff  <= 1'b1;
              state_ff   <= ST_RDVALID;
            end
          end
        end
        ST_RDFETCH:
        begin
          if (flashRdValid)
          begin
            dataOut_ff <= flashRdata;
            dataOe_ff  <= 1'b1;
            addr_ff    <= addr_ff + 32'h00000001;
            state_ff   <= ST_RDVALID;
          end
        end
        ST_RDVALID:
        begin
          valid_ff <= 1'b0;
          state_ff <= ST_RDHOLD;
        end
        ST_RDHOLD:
        begin
          if (oeNF)
          begin
            dataOe_ff <= 1'b0;
            state_ff  <= ST_RDEND;
          end
        end
        ST_RDEND:
        begin
          valid_ff <= 1'b1;
          state_ff <= ST_WAITHI;
        end
        ST_WAITHI:
        begin
          if (cmdNF)
          begin
            ready_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign dataOut     = dataOut_ff;
  assign dataOe      = dataOe_ff;
  assign ready       = ready_ff;
  assign dataValidN  = valid_ff;
  assign flashOp     = flashOp_ff;
  assign flashOpSel  = opSel_ff;
  assign flashAddr   = flashAddr_ff;
  assign flashLen    = flashLen_ff;
  assign flashWdata  = wdata_ff;
  assign flashWvalid = wvalid_ff;
  assign flashRdReq  = rdReq_ff;
  assign lockBits    = lock_ff;
  assign userBits    = user_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  drive_then_valid_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    $rose(dataOe_ff) |-> !oeNF ##1 !valid_ff)
    else $error("data valid not lowered after driving");
  float_before_valid_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    $rose(valid_ff) |-> !dataOe_ff && $past(!dataOe_ff))
    else $error("data valid raised while bus driven");
  ready_on_strobe_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    $rose(ready_ff) |-> $past(cmdNF) && valid_ff && !dataOe_ff)
    else $error("ready raised without strobe high");
  busy_during_op_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    (flashOp_ff || state_ff inside {ST_ERASE, ST_PROG, ST_ERALL}) |-> !ready_ff)
    else $error("ready high during flash operation");
  cmd_commits_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    (ce && state_ff == ST_DECODE && dirty && mode_ff == pfp_pkg::MODE_CMD) |=> flashOp_ff && cmd_ff == $past(cmd_ff))
    else $error("command accepted with uncommitted page");
  erase_lock_abort_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    (flashOp_ff && opSel_ff == pfp_pkg::OP_ERASE_ALL) |-> lock_ff == 16'h0000 && word_ff == 16'h0000)
    else $error("full erase started while locked");
  erase_clears_bits_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    (ce && state_ff == ST_ERALL && flashDone) |=> lock_ff == 16'h0000 && user_ff == 16'h0000 && ready_ff == 1'b0)
    else $error("full erase left bits set");
  lock_after_prog_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    (ce && state_ff == ST_PROG && flashDone && isLockVar) |=> lock_ff[$past(lockIdx)])
    else $error("lock bit not set after write and lock");
  read_advance_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    (ce && state_ff == ST_RDFETCH && flashRdValid) |=> addr_ff == $past(addr_ff) + 32'h00000001)
    else $error("read address not advanced");
  no_cmd_ignored_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    (state_ff == ST_DECODE && cmd_ff == pfp_pkg::CMD_NONE && !needCommit) |=> state_ff == ST_WAITHI)
    else $error("data without command not ignored");

endmodule

/* File: pfp_flash_model.sv */
// behavioural flash array answering the back-end port
`timescale 1ns/1ps
module pfp_flash_model (
  input  wire logic        clk_sys,
  input  wire logic        flashOp,
  input  wire logic [1:0]  flashOpSel,
  input  wire logic [31:0] flashAddr,
  input  wire logic [4:0]  flashLen,
  input  wire logic [15:0] flashWdata,
  input  wire logic        flashWvalid,
  output logic             flashWready,
  output logic             flashDone,
  input  wire logic        flashRdReq,
  output logic             flashRdValid,
  output logic [15:0]      flashRdata
);
  // only 256 words modelled; higher address bits alias
  logic [15:0] mem [256];
  logic [7:0]  wAddr;
  int          left;
  logic        busy;
  initial
  begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {flashWready, flashDone, flashRdValid, busy, flashRdata} = '0;
  end
  always @(posedge clk_sys)
  begin
    flashDone <= 1'b0;
    flashRdValid <= flashRdReq;
    // stalls every other cycle; rdata wiggles when not valid
    flashWready <= ~flashWready;
    flashRdata <= flashRdReq ? mem[flashAddr[7:0]] : ~flashRdata;
    if (flashOp)
    begin
      wAddr <= flashAddr[7:0];
      left <= (flashOpSel == pfp_pkg::OP_PROGRAM) ? int'(flashLen) : 0;
      busy <= 1'b1;
      for (int i = 0; i < 256; i++)
        if (flashOpSel == pfp_pkg::OP_ERASE_ALL || (flashOpSel == pfp_pkg::OP_ERASE_PAGE && i[7:4] == flashAddr[7:4]))
          mem[i] <= 16'hFFFF;
    end
    else if (flashWvalid)
    begin
      mem[wAddr] <= flashWdata;
      wAddr <= wAddr + 8'h01;
      left <= left - 1;
    end
    else if (busy && left == 0)
    begin
      flashDone <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

/* File: tb_parallel_flash_program_port.sv */
// self-checking bench driving the programmer handshakes
`timescale 1ns/1ps
module tb_parallel_flash_program_port;
  logic clk_sys = 1'b0, nrst = 1'b0, commandStrobeN = 1'b1, outputEnableN = 1'b1;
  logic [3:0] modeSel = 4'h0;
  logic [15:0] dataIn = 16'h0000, dataOut, flashWdata, flashRdata, lockBits, userBits;
  logic dataOe, ready, dataValidN, flashOp, flashWvalid, flashWready, flashDone, flashRdReq, flashRdValid;
  logic [1:0] flashOpSel;
  logic [31:0] flashAddr;
  logic [4:0] flashLen;
  int n_fail = 0, checked = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  pfp_flash_port dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .commandStrobeN(commandStrobeN),
    .outputEnableN(outputEnableN), .modeSel(modeSel), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .ready(ready), .dataValidN(dataValidN), .flashOp(flashOp), .flashOpSel(flashOpSel), .flashAddr(flashAddr),
    .flashLen(flashLen), .flashWdata(flashWdata), .flashWvalid(flashWvalid), .flashWready(flashWready),
    .flashDone(flashDone), .flashRdReq(flashRdReq), .flashRdValid(flashRdValid), .flashRdata(flashRdata),
    .lockBits(lockBits), .userBits(userBits));
  pfp_flash_model fm (.clk_sys(clk_sys), .flashOp(flashOp), .flashOpSel(flashOpSel), .flashAddr(flashAddr),
    .flashLen(flashLen), .flashWdata(flashWdata), .flashWvalid(flashWvalid), .flashWready(flashWready),
    .flashDone(flashDone), .flashRdReq(flashRdReq), .flashRdValid(flashRdValid), .flashRdata(flashRdata));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ceiling well above the longest sequence
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // k 0 waits on ready, k 1 on data valid
  task automatic wt(int k, logic v);
    int i;
    for (i = 0; i < 400; i++)
    begin
      @(negedge clk_sys);
      if ((k == 0 ? ready : dataValidN) === v) break;
    end
    if (i == 400) chk(16'h0001, 16'h0000);
  endtask
  task automatic wr(logic [3:0] m, logic [15:0] d);
    modeSel = m;
    dataIn = d;
    repeat (5) @(negedge clk_sys);
    commandStrobeN = 1'b0;
    wt(0, 1'b0);
    commandStrobeN = 1'b1;
    wt(0, 1'b1);
  endtask
  task automatic rd(logic [15:0] e);
    modeSel = pfp_pkg::MODE_DATA;
    repeat (5) @(negedge clk_sys);
    commandStrobeN = 1'b0;
    wt(0, 1'b0);
    dataIn = ~dataIn;
    outputEnableN = 1'b0;
    wt(1, 1'b0);
    chk(dataOut, e);
    chk({15'h0000, dataOe}, 16'h0001);
    outputEnableN = 1'b1;
    wt(1, 1'b1);
    chk({15'h0000, dataOe}, 16'h0000);
    commandStrobeN = 1'b1;
    wt(0, 1'b1);
  endtask
  task automatic at(logic [15:0] a);
    wr(pfp_pkg::MODE_ADDR_LO, a);
    wr(pfp_pkg::MODE_ADDR_HI, 16'h0000);
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    wr(pfp_pkg::MODE_DATA, 16'h1234);
    wr(4'h3, 16'h0013);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_PAGE_WRITE);
    at(16'h0010);
    wr(pfp_pkg::MODE_DATA, 16'hA5C3);
    wr(pfp_pkg::MODE_DATA, 16'h5A3C);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_READ);
    at(16'h0011);
    rd(16'h5A3C);
    at(16'h0010);
    rd(16'hA5C3);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_ERASE_WRITE);
    at(16'h0012);
    wr(pfp_pkg::MODE_DATA, 16'h0F0F);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_READ);
    at(16'h0011);
    rd(16'hFFFF);
    rd(16'h0F0F);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_PAGE_WRITE_LOCK);
    at(16'h0070);
    wr(pfp_pkg::MODE_DATA, 16'h7777);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_ERASE_WRITE_LCK);
    at(16'h00F0);
    wr(pfp_pkg::MODE_DATA, 16'h1111);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_GET_LOCK);
    rd(16'h0003);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_SET_LOCK);
    wr(pfp_pkg::MODE_DATA, 16'h8004);
    chk(lockBits, 16'h8007);
    wr(4'h7, 16'h0010);
    chk(lockBits, 16'h8007);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_FULL_ERASE);
    wr(pfp_pkg::MODE_DATA, 16'h0000);
    chk(lockBits, 16'h8007);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_READ);
    at(16'h0070);
    rd(16'h7777);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_CLEAR_LOCK);
    wr(pfp_pkg::MODE_DATA, 16'h8007);
    chk(lockBits, 16'h0000);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_SET_USER_BIT);
    wr(pfp_pkg::MODE_DATA, 16'h0005);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_CLEAR_USER_BIT);
    wr(pfp_pkg::MODE_DATA, 16'h0001);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_GET_USER_BIT);
    rd(16'h0004);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_FULL_ERASE);
    wr(pfp_pkg::MODE_DATA, 16'h0000);
    chk(userBits, 16'h0000);
    wr(pfp_pkg::MODE_CMD, pfp_pkg::CMD_READ);
    at(16'h0012);
    rd(16'hFFFF);
    summarize();
  end
endmodule
